/* hdl/l2ld_pkg.sv */
/*
 * Package for the loop-two lock-detect register bank: register offsets,
 * field positions, reset values and timing constants.
 * Assumes a 125 MHz APB clock and one-word-per-register APB mapping.
 */
// Operation
// RQ1: Lock count is 14 bits: six high bits in first register, eight low in second.
// RQ2: Lock indicator rises only after lock-count consecutive in-window comparisons.
// RQ3: Each comparison tested against selected phase window; out-of-window never counts.
// RQ4: Pulse-request enable bit lets sync request pin trigger continuous pulses.
// RQ5: Software using pin-requested pulses also sets source selector to pulser, two.
// RQ6: Loop-filter bits 5:3 select R4; codes 0-4 valid, 5-7 reserved.
// RQ7: Loop-filter bits 2:0 select R3 with same code map; 5-7 reserved.
// RQ8: Window field two bits; only code 2 valid, selecting 3.7 ns.
// RQ9: Lock count zero is invalid; count restarts on any out-of-window comparison.
package l2ld_pkg;
   // Printed offsets are not multiples of four: they are word indexes
   localparam logic [11:0] L2LD_IDX_CNT_HI   = 12'h16a;
   localparam logic [11:0] L2LD_IDX_CNT_LO   = 12'h16b;
   localparam logic [11:0] L2LD_IDX_FILTER   = 12'h16c;
   localparam logic [11:0] L2LD_IDX_WINDOW   = 12'h170;
   localparam logic [11:0] L2LD_IDX_STATUS   = 12'h171;
   localparam logic [11:0] L2LD_IDX_IRQ_STAT = 12'h172;
   localparam logic [11:0] L2LD_IDX_IRQ_MASK = 12'h173;

   localparam logic [7:0] L2LD_RST_CNT_HI = 8'h20;
   localparam logic [7:0] L2LD_RST_CNT_LO = 8'h00;
   localparam logic [7:0] L2LD_RST_FILTER = 8'h00;
   localparam logic [1:0] L2LD_RST_WINDOW = 2'h2;

   localparam int L2LD_POS_PULSE_EN = 6;
   localparam int L2LD_POS_R4_LSB   = 3;
   localparam int L2LD_POS_R3_LSB   = 0;
   localparam int L2LD_CNT_W        = 14;
   localparam int L2LD_CNT_HI_W     = 6;

   localparam logic [1:0] L2LD_WINDOW_VALID = 2'h2;
   localparam logic [2:0] L2LD_RES_MAX_CODE = 3'h4;

   // Window of 3.7 ns at 8 ns clock: longest time, rounded down, min one
   localparam real L2LD_WINDOW_NS  = 3.7;
   localparam real L2LD_CLK_NS     = 8.0;
   localparam int  L2LD_WINDOW_CYC = (int'($floor(L2LD_WINDOW_NS / L2LD_CLK_NS)) < 1) ? 1 :
                                     int'($floor(L2LD_WINDOW_NS / L2LD_CLK_NS));

   // Interrupt bit positions
   localparam int L2LD_IRQ_LOCK   = 0;
   localparam int L2LD_IRQ_UNLOCK = 1;
   localparam int L2LD_IRQ_BADCFG = 2;
   localparam int L2LD_IRQ_W      = 3;
endpackage : l2ld_pkg

/* hdl/l2ld_lock_counter.sv */
/*
 * Consecutive in-window comparison counter that drives the lock indicator.
 * Assumes compare strobes and in-window flags arrive on pclk, already synced.
 */
`timescale 1ns/1ps
module l2ld_lock_counter #(
   parameter int CNT_W = l2ld_pkg::L2LD_CNT_W
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             clk_en,
   input  wire logic             cmp_strobe,
   input  wire logic             cmp_in_window,
   input  wire logic [CNT_W-1:0] lock_target,
   input  wire logic             cfg_ok,
   output logic                  locked
);
   import l2ld_pkg::*;

   logic [CNT_W-1:0] run_q;

   // Run length saturates at the target; a miss restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= '0;
      end else if (clk_en) begin
         if (!cfg_ok) begin
            run_q <= '0;
         end else if (cmp_strobe) begin
            if (!cmp_in_window) begin
               run_q <= '0;                 // see RQ3 see RQ9
            end else if (run_q < lock_target) begin
               run_q <= run_q + CNT_W'(1);
            end
         end
      end
   end

   // Zero target never locks, since software must not program it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locked <= 1'b0;
      end else if (clk_en) begin
         locked <= cfg_ok && (lock_target != '0) && (run_q >= lock_target);  // see RQ2
      end
   end
endmodule : l2ld_lock_counter

/* hdl/l2ld_regs.sv */
/*
 * Loop-two lock-detect register bank with APB slave, sync-request routing,
 * loop-filter resistor selects and lock interrupt.
 * Assumes the phase detector supplies a compare strobe and measured phase
 * error on pclk; sync request arrives asynchronously from a pin.
 */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module l2ld_regs (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [13:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        cmp_strobe,
   input  wire logic [7:0]  phase_err_cycles,
   input  wire logic        sync_request_pin,
   output logic             sysref_pulse_trigger,
   output logic             sync_trigger,
   output logic [2:0]       loop2_filter_res_four,
   output logic [2:0]       loop2_filter_res_three,
   output logic [1:0]       loop2_phase_window,
   output logic             lock_indicator,
   output logic             irq
);
   import l2ld_pkg::*;

   logic [7:0]  cnt_hi_q;
   logic [7:0]  cnt_lo_q;
   logic [7:0]  filter_q;
   logic [1:0]  window_q;
   logic [L2LD_IRQ_W-1:0] irq_stat_q;
   logic [L2LD_IRQ_W-1:0] irq_mask_q;
   logic [L2LD_IRQ_W-1:0] irq_evt;
   logic [1:0]  sync_ff_q;
   logic        lock_prev_q;
   logic        bad_prev_q;
   logic        locked;
   logic        cfg_ok;
   logic        in_window;
   logic        wr_acc;
   logic        rd_acc;
   logic        addr_ok;
   logic [11:0] idx;
   logic [13:0] loop2_lock_count;
   logic [31:0] rd_d;
   logic        misaligned;
   logic        bad_res;
   logic        bad_cfg;
   logic        pin_synced;
   logic        pulse_mode;
   logic        we_cnt_hi;
   logic        we_cnt_lo;
   logic        we_filter;
   logic        we_window;
   logic        we_mask;
   logic        rd_irq_stat;
   logic [L2LD_IRQ_W-1:0] irq_clr;

   // Register words, byte address four times the index:
   //   lock_count_high_and_pulse_req  bit 6 pulse-request enable, bits 5:0 lock count high
   //   lock_count_low  lock count low byte
   //   loop_filter_resistors  bits 5:3 and 2:0 resistor selects
   //   0x170  bits 1:0 phase window select
   //   0x171  status: bit 2 synced pin, bit 1 config ok, bit 0 locked
   //   0x172  sticky events: bit 2 bad config, bit 1 lock lost, bit 0 lock
   //   0x173  event mask, same layout

   // Word index from byte address; a misaligned access is refused outright
   assign idx        = paddr[13:2];
   assign misaligned = paddr[1:0] != 2'h0;
   assign wr_acc     = psel && penable && pwrite && clk_en && !misaligned;
   assign rd_acc     = psel && penable && !pwrite && clk_en && !misaligned;
   assign pready     = 1'b1;

   // Per-register write strobes; only the low byte lane carries data
   assign we_cnt_hi   = wr_acc && pstrb[0] && (idx == L2LD_IDX_CNT_HI);
   assign we_cnt_lo   = wr_acc && pstrb[0] && (idx == L2LD_IDX_CNT_LO);
   assign we_filter   = wr_acc && pstrb[0] && (idx == L2LD_IDX_FILTER);
   assign we_window   = wr_acc && pstrb[0] && (idx == L2LD_IDX_WINDOW);
   assign we_mask     = wr_acc && pstrb[0] && (idx == L2LD_IDX_IRQ_MASK);
   assign rd_irq_stat = rd_acc && (idx == L2LD_IDX_IRQ_STAT);

   // Decode of the mapped words
   always_comb begin
      if (idx == L2LD_IDX_CNT_HI) begin
         addr_ok = 1'b1;
      end else if (idx == L2LD_IDX_CNT_LO) begin
         addr_ok = 1'b1;
      end else if (idx == L2LD_IDX_FILTER) begin
         addr_ok = 1'b1;
      end else if (idx == L2LD_IDX_WINDOW) begin
         addr_ok = 1'b1;
      end else if (idx == L2LD_IDX_STATUS) begin
         addr_ok = 1'b1;
      end else if (idx == L2LD_IDX_IRQ_STAT) begin
         addr_ok = 1'b1;
      end else if (idx == L2LD_IDX_IRQ_MASK) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // Unmapped or misaligned words answer with an error
   assign pslverr = psel && penable && (!addr_ok || misaligned);

   // Lock count high bits and pulse-request enable; bit 7 stays zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_hi_q <= L2LD_RST_CNT_HI;
      end else if (we_cnt_hi) begin
         cnt_hi_q <= {1'b0, pwdata[6:0]};  // see RQ1 see RQ4
      end
   end

   // Lock count low byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_lo_q <= L2LD_RST_CNT_LO;
      end else if (we_cnt_lo) begin
         cnt_lo_q <= pwdata[7:0];          // see RQ1
      end
   end

   // Resistor selects; reserved codes are stored but flagged as bad
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filter_q <= L2LD_RST_FILTER;
      end else if (we_filter) begin
         filter_q <= {2'h0, pwdata[5:0]};  // see RQ6 see RQ7
      end
   end

   // Window size select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         window_q <= L2LD_RST_WINDOW;
      end else if (we_window) begin
         window_q <= pwdata[1:0];           // see RQ8
      end
   end

   assign loop2_lock_count       = {cnt_hi_q[L2LD_CNT_HI_W-1:0], cnt_lo_q};  // see RQ1
   assign loop2_filter_res_four  = filter_q[L2LD_POS_R4_LSB +: 3];         // see RQ6
   assign loop2_filter_res_three = filter_q[L2LD_POS_R3_LSB +: 3];         // see RQ7
   assign loop2_phase_window     = window_q;

   // Counting is held off under a reserved window or zero count
   assign cfg_ok    = (window_q == L2LD_WINDOW_VALID) && (loop2_lock_count != '0);  // see RQ8
   assign in_window = phase_err_cycles < 8'(L2LD_WINDOW_CYC + 1);          // see RQ3

   // Reserved resistor codes are kept as written but reported as bad config
   assign bad_res = (loop2_filter_res_four > L2LD_RES_MAX_CODE)
                    || (loop2_filter_res_three > L2LD_RES_MAX_CODE);  // see RQ6 see RQ7
   assign bad_cfg = !cfg_ok || bad_res;

   l2ld_lock_counter #(
      .CNT_W (L2LD_CNT_W)
   ) u_counter (
      .pclk          (pclk),
      .presetn       (presetn),
      .clk_en        (clk_en),
      .cmp_strobe    (cmp_strobe),
      .cmp_in_window (in_window),
      .lock_target   (loop2_lock_count),
      .cfg_ok        (cfg_ok),
      .locked        (locked)
   );

   assign lock_indicator = locked;  // see RQ2

   // Pin is asynchronous: two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_ff_q <= 2'h0;
      end else if (clk_en) begin
         sync_ff_q <= {sync_ff_q[0], sync_request_pin};
      end
   end

   // Only the second flop is read, so no metastable value leaks onward
   assign pin_synced = sync_ff_q[1];
   assign pulse_mode = cnt_hi_q[L2LD_POS_PULSE_EN];

   // Pulse mode: the synced pin fires the pulser and never the normal sync
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sysref_pulse_trigger <= 1'b0;
      end else if (clk_en) begin
         sysref_pulse_trigger <= pin_synced && pulse_mode;   // see RQ4
      end
   end

   // Normal sync use whenever pulse mode is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_trigger <= 1'b0;
      end else if (clk_en) begin
         sync_trigger <= pin_synced && !pulse_mode;          // see RQ4
      end
   end

   // Lock history for rise and fall events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_prev_q <= 1'b0;
      end else if (clk_en) begin
         lock_prev_q <= locked;
      end
   end

   // Bad-config history; power-on config is good, so no false event after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_prev_q <= 1'b0;
      end else if (clk_en) begin
         bad_prev_q <= bad_cfg;
      end
   end

   assign irq_evt[L2LD_IRQ_LOCK]   = locked && !lock_prev_q;
   assign irq_evt[L2LD_IRQ_UNLOCK] = !locked && lock_prev_q;
   assign irq_evt[L2LD_IRQ_BADCFG] = bad_cfg && !bad_prev_q;

   // A read clears only the bits it returned; read data was loaded in setup,
   // so an event landing between setup and access survives the clear
   assign irq_clr = rd_irq_stat ? prdata[L2LD_IRQ_W-1:0] : '0;

   // Sticky status per bit; a new event in the clearing cycle wins
   for (genvar b = 0; b < L2LD_IRQ_W; b++) begin : g_irq_bit
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            irq_stat_q[b] <= 1'b0;
         end else if (clk_en) begin
            irq_stat_q[b] <= (irq_stat_q[b] && !irq_clr[b]) || irq_evt[b];
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_q <= '0;
      end else if (we_mask) begin
         irq_mask_q <= pwdata[L2LD_IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // Read mux
   always_comb begin
      rd_d = 32'h0000_0000;
      if (misaligned) begin
         rd_d = 32'h0000_0000;             // Refused word reads zero
      end else if (idx == L2LD_IDX_CNT_HI) begin
         rd_d[7:0] = cnt_hi_q;
      end else if (idx == L2LD_IDX_CNT_LO) begin
         rd_d[7:0] = cnt_lo_q;
      end else if (idx == L2LD_IDX_FILTER) begin
         rd_d[7:0] = filter_q;
      end else if (idx == L2LD_IDX_WINDOW) begin
         rd_d[1:0] = window_q;
      end else if (idx == L2LD_IDX_STATUS) begin
         rd_d[2:0] = {sync_ff_q[1], cfg_ok, locked};
      end else if (idx == L2LD_IDX_IRQ_STAT) begin
         rd_d[L2LD_IRQ_W-1:0] = irq_stat_q;
      end else if (idx == L2LD_IDX_IRQ_MASK) begin
         rd_d[L2LD_IRQ_W-1:0] = irq_mask_q;
      end
   end

   // Read data registered in setup so it is valid in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && psel && !penable && !pwrite) begin
         prdata <= rd_d;
      end
   end
endmodule : l2ld_regs

/* verif/l2ld_checker.sv */
/* Port checker for the loop-two lock-detect register bank.
   Assumes one pclk domain and that it is bound onto l2ld_regs. */
`timescale 1ns/1ps
module l2ld_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        cmp_strobe,
   input wire logic [7:0]  phase_err_cycles,
   input wire logic        sync_request_pin,
   input wire logic        sysref_pulse_trigger,
   input wire logic        sync_trigger,
   input wire logic [2:0]  loop2_filter_res_four,
   input wire logic [2:0]  loop2_filter_res_three,
   input wire logic [1:0]  loop2_phase_window,
   input wire logic        lock_indicator
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Enabled write to the filter register
   wire f_wr = psel && penable && pwrite && clk_en && pstrb[0] && paddr == 14'h5b0;
   a_filter_fields: assert property (
      f_wr |=> loop2_filter_res_four == $past(pwdata[5:3]) &&
               loop2_filter_res_three == $past(pwdata[2:0])) else $error("filter fields wrong");
   a_trig_exclusive: assert property (
      !(sysref_pulse_trigger && sync_trigger)) else $error("both triggers high");
   a_trig_source: assert property (
      sync_trigger || sysref_pulse_trigger |-> $past(sync_request_pin, 3))
      else $error("trigger without pin");
   a_lock_after_cmp: assert property (
      $rose(lock_indicator) |-> $past(cmp_strobe) || $past(cmp_strobe, 2))
      else $error("lock rose without comparison");
   a_miss_unlock: assert property (
      cmp_strobe && clk_en && phase_err_cycles > 8'h01 |-> ##[1:3] !lock_indicator)
      else $error("lock kept after miss");
   a_bad_window: assert property (
      (loop2_phase_window != 2'h2) [*3] |-> !lock_indicator) else $error("lock on bad window");
   a_misalign_err: assert property (
      psel && penable && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned not refused");
   a_cnt_hi_read: assert property (
      psel && penable && !pwrite && paddr == 14'h5a8 |-> prdata[31:7] == 25'h0)
      else $error("count high readback too wide");
   // Main scenarios reached
   c_lock: cover property ($rose(lock_indicator));
   c_pulse: cover property (sysref_pulse_trigger);
   c_err: cover property (psel && penable && pslverr);
endmodule : l2ld_checker

bind l2ld_regs l2ld_checker l2ld_checker_inst (.pclk, .presetn, .clk_en, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .cmp_strobe, .phase_err_cycles,
   .sync_request_pin, .sysref_pulse_trigger, .sync_trigger, .loop2_filter_res_four,
   .loop2_filter_res_three, .loop2_phase_window, .lock_indicator);

/* verif/tb.sv */
/* Self-checking bench for l2ld_regs: APB master tasks and one task per scenario.
   Assumes the package offsets are word indexes and pready answers in the access phase. */
`timescale 1ns/1ps
module tb;
   import l2ld_pkg::*;
   localparam logic [13:0] A_HI  = {L2LD_IDX_CNT_HI, 2'b00};
   localparam logic [13:0] A_LO  = {L2LD_IDX_CNT_LO, 2'b00};
   localparam logic [13:0] A_FLT = {L2LD_IDX_FILTER, 2'b00};
   localparam logic [13:0] A_WIN = {L2LD_IDX_WINDOW, 2'b00};
   localparam logic [13:0] A_ST  = {L2LD_IDX_STATUS, 2'b00};
   localparam logic [13:0] A_IST = {L2LD_IDX_IRQ_STAT, 2'b00};
   localparam logic [13:0] A_MSK = {L2LD_IDX_IRQ_MASK, 2'b00};
   logic        pclk, presetn, clk_en, psel, penable, pwrite, cmp_strobe, sync_request_pin;
   logic        pready, pslverr, sysref_pulse_trigger, sync_trigger, lock_indicator, irq;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [7:0]  phase_err_cycles;
   logic [2:0]  loop2_filter_res_four, loop2_filter_res_three;
   logic [1:0]  loop2_phase_window;
   logic        er;
   int          n_fail, checks, cyc;

   l2ld_regs l2ld_regs_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .pready, .prdata, .pslverr, .cmp_strobe, .phase_err_cycles,
      .sync_request_pin, .sysref_pulse_trigger, .sync_trigger, .loop2_filter_res_four,
      .loop2_filter_res_three, .loop2_phase_window, .lock_indicator, .irq);

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Setup cycle, then access held until pready is seen high
   task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [13:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rdc

   task automatic strobe(input logic [7:0] e);
      @(posedge pclk);
      cmp_strobe <= 1'b1; phase_err_cycles <= e;
      @(posedge pclk);
      cmp_strobe <= 1'b0;
   endtask : strobe

   task automatic t_reset;
      rdc(A_HI, 32'h20, "cnt_hi");
      rdc(A_LO, 32'h0, "cnt_lo");
      rdc(A_FLT, 32'h0, "filter");
      chk("window", 32'h2, 32'(loop2_phase_window));
      $display("test reset done");
   endtask : t_reset

   // Count of three; a miss in mid-run must restart it
   task automatic t_lock;
      apb(1'b1, A_MSK, 32'h1);
      // Low byte first, so the count never passes through zero
      apb(1'b1, A_LO, 32'h3);
      apb(1'b1, A_HI, 32'h0);
      apb(1'b0, A_IST, 32'h0);
      strobe(8'h0); strobe(8'h1); strobe(8'h2); strobe(8'h0); strobe(8'h1);
      repeat (3) @(posedge pclk);
      chk("lock early", 32'h0, 32'(lock_indicator));
      strobe(8'h1);
      repeat (3) @(posedge pclk);
      chk("lock", 32'h1, 32'(lock_indicator));
      chk("irq", 32'h1, 32'(irq));
      rdc(A_ST, 32'h3, "status");
      rdc(A_IST, 32'h1, "irq status");
      @(posedge pclk);
      chk("irq cleared", 32'h0, 32'(irq));
      apb(1'b1, A_WIN, 32'h1);
      repeat (3) @(posedge pclk);
      chk("lock bad window", 32'h0, 32'(lock_indicator));
      apb(1'b1, A_WIN, 32'h2);
      $display("test lock done");
   endtask : t_lock

   task automatic t_pulse;
      sync_request_pin <= 1'b1;
      repeat (5) @(posedge pclk);
      chk("sync", 32'h2, 32'({sync_trigger, sysref_pulse_trigger}));
      // Pulse mode assumes the source selector outside this bank picks the pulser
      apb(1'b1, A_HI, 32'hc0);
      repeat (4) @(posedge pclk);
      chk("pulse", 32'h2, 32'({sysref_pulse_trigger, sync_trigger}));
      rdc(A_HI, 32'h40, "cnt_hi enable");
      sync_request_pin <= 1'b0;
      $display("test pulse done");
   endtask : t_pulse

   task automatic t_filter;
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, A_FLT, 32'(i * 8 + 4 - i));
         @(posedge pclk);
         chk("res four", 32'(i), 32'(loop2_filter_res_four));
         chk("res three", 32'(4 - i), 32'(loop2_filter_res_three));
      end
      apb(1'b1, A_FLT, 32'hff);
      rdc(A_FLT, 32'h3f, "filter reserved");
      clk_en <= 1'b0;
      apb(1'b1, A_FLT, 32'h0);
      clk_en <= 1'b1;
      @(posedge pclk);
      chk("frozen", 32'h7, 32'(loop2_filter_res_four));
      apb(1'b1, A_FLT | 14'h1, 32'h0);
      chk("misaligned err", 32'h1, 32'(er));
      @(posedge pclk);
      chk("misaligned kept", 32'h7, 32'(loop2_filter_res_three));
      apb(1'b0, 14'h0, 32'h0);
      chk("unmapped err", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rd);
      $display("test filter done");
   endtask : t_filter

   task automatic report_and_stop;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // Free-running clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Hang guard, far above the roughly 120 cycles the tests need
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   // Main sequence
   initial begin
      presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 14'h0; pwdata = 32'h0; pstrb = 4'hf; cmp_strobe = 1'b0;
      phase_err_cycles = 8'h0; sync_request_pin = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_lock();
      t_pulse();
      t_filter();
      report_and_stop();
   end
endmodule : tb
